// File: src/scbv_pkg.sv
package scbv_pkg;

    // Core geometry.
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned INSTR_W = 18;
    localparam int unsigned NUM_REGS = 16;
    localparam int unsigned STACK_DEPTH = 30;
    localparam int unsigned SP_W = 5;
    localparam logic [ADDR_W-1:0] PC_RESET = 12'h000;

    // Instruction fields.
    localparam int unsigned OPC_HI = 17;
    localparam int unsigned OPC_LO = 12;
    localparam int unsigned DST_HI = 11;
    localparam int unsigned DST_LO = 8;
    localparam int unsigned SRC_HI = 7;
    localparam int unsigned SRC_LO = 4;
    localparam int unsigned KK_HI = 7;
    localparam int unsigned KK_LO = 0;
    localparam int unsigned KVAL_HI = 11;
    localparam int unsigned KVAL_LO = 4;
    localparam int unsigned KPORT_HI = 3;
    localparam int unsigned KPORT_LO = 0;

    // Opcodes.
    localparam logic [5:0] OP_LOAD_R = 6'h00;
    localparam logic [5:0] OP_LOAD_K = 6'h01;
    localparam logic [5:0] OP_INPUT = 6'h09;
    localparam logic [5:0] OP_FETCH = 6'h0b;
    localparam logic [5:0] OP_ADD_R = 6'h10;
    localparam logic [5:0] OP_ADD_K = 6'h11;
    localparam logic [5:0] OP_ADDCY_R = 6'h12;
    localparam logic [5:0] OP_ADDCY_K = 6'h13;
    localparam logic [5:0] OP_HWBUILD = 6'h14;
    localparam logic [5:0] OP_CALL = 6'h20;
    localparam logic [5:0] OP_LOAD_RET = 6'h21;
    localparam logic [5:0] OP_JUMP = 6'h22;
    localparam logic [5:0] OP_CALL_IND = 6'h24;
    localparam logic [5:0] OP_RETURN = 6'h25;
    localparam logic [5:0] OP_CONSTANT_PORT_OUTPUT = 6'h2b;
    localparam logic [5:0] OP_OUTPUT = 6'h2d;
    localparam logic [5:0] OP_STORE = 6'h2f;

    // Wishbone register map, byte addresses.
    localparam int unsigned WB_ADR_W = 4;
    localparam logic [WB_ADR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [WB_ADR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [WB_ADR_W-1:0] REG_CONFIG = 4'h8;
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RESET = 1'b1;
    localparam int unsigned ST_ZERO_BIT = 12;
    localparam int unsigned ST_CARRY_BIT = 13;
    localparam int unsigned ST_SLEEP_BIT = 14;
    localparam int unsigned ST_RUN_BIT = 15;
    localparam int unsigned CFG_BUILD_LO = 0;
    localparam int unsigned CFG_VEC_LO = 8;
    localparam int unsigned CFG_SCR_LO = 20;

    typedef enum logic {
        CORE_FETCH,
        CORE_EXEC
    } scbv_core_state_t;

    typedef struct packed {
        logic [7:0] port_id;
        logic [7:0] data;
        logic write_strobe;
        logic const_write_strobe;
        logic read_strobe;
    } scbv_port_bus_t;

endpackage

// File: src/scbv_scratch.sv
`timescale 1ns/1ps
module scbv_scratch
    import scbv_pkg::*;
#(
    parameter int unsigned SIZE = 64
) (
    // Clock.
    input wire logic clk_i,
    // Access.
    input wire logic we_i,
    input wire logic [7:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic [DATA_W-1:0] rdata_o
);

    localparam int unsigned AW = $clog2(SIZE);

    initial begin
        if (SIZE != 64 && SIZE != 128 && SIZE != 256) begin
            $error("scratch size must be 64, 128 or 256");
        end
    end

    logic [DATA_W-1:0] mem [SIZE];
    logic [AW-1:0] idx;

    // Upper address bits fold over, so small memories alias as a mirror.
    assign idx = addr_i[AW-1:0];
    assign rdata_o = mem[idx];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[idx] <= wdata_i;
        end
    end

endmodule // scbv_scratch

// File: src/scbv_core.sv
`timescale 1ns/1ps
// Behaviour
// - Build-value load writes the 8-bit build constant to its register.
// - Build-value load sets zero if the constant is zero, else clears it.
// - Build-value load always sets carry to one.
// - A 12-bit instruction address reaches program memory, 4K locations.
// - With sleep held low, execution is exactly as without sleep.
// - Constant-output instruction alone pulses its own write strobe.
// - Three parameters: scratch size, interrupt target, build value.
// - Defaults give 64 scratch bytes and interrupt target 3FF.
// - Indirect call jumps to register-pair address and pushes return.
// - Load-and-return loads a constant, pops and increments; two cycles.
module scbv_core
    import scbv_pkg::*;
#(
    parameter logic [DATA_W-1:0] HWBUILD_VALUE = 8'h00,
    parameter logic [ADDR_W-1:0] INTERRUPT_VECTOR = 12'h3ff,
    parameter int unsigned SCRATCH_SIZE = 64
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Program memory.
    output logic [ADDR_W-1:0] address_o,
    output logic bram_enable_o,
    input wire logic [INSTR_W-1:0] instruction_i,
    // Power control.
    input wire logic sleep_i,
    // I/O ports.
    output scbv_port_bus_t port_bus_o,
    input wire logic [DATA_W-1:0] in_port_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    typedef struct packed {
        scbv_core_state_t state;
        logic [ADDR_W-1:0] pc;
        logic [NUM_REGS-1:0][DATA_W-1:0] regs;
        logic [STACK_DEPTH-1:0][ADDR_W-1:0] stack;
        logic [SP_W-1:0] sp;
        logic zero;
        logic carry;
        logic [3:0] in_dst;
        scbv_port_bus_t ports;
        logic run;
        logic wb_ack;
        logic [31:0] wb_dat;
    } scbv_core_st_t;

    initial begin
        if (SCRATCH_SIZE != 64 && SCRATCH_SIZE != 128 &&
            SCRATCH_SIZE != 256) begin
            $error("SCRATCH_SIZE must be 64, 128 or 256");
        end
    end

    scbv_core_st_t st;
    scbv_core_st_t next_st;

    logic exec_now;
    logic [5:0] opc;
    logic [3:0] dst;
    logic [3:0] src;
    logic [DATA_W-1:0] kk;
    logic [ADDR_W-1:0] aaa;
    logic [ADDR_W-1:0] ret_addr;
    logic [ADDR_W-1:0] ind_addr;
    logic [DATA_W-1:0] operand;
    logic use_cy;
    logic [DATA_W:0] sum;
    logic can_push;
    logic can_pop;
    logic scr_we;
    logic [DATA_W-1:0] scr_rdata;
    logic [31:0] status_word;
    logic [31:0] config_word;
    logic [8:0] scratch_code;

    assign exec_now = (st.state == CORE_EXEC);
    assign opc = instruction_i[OPC_HI:OPC_LO];
    assign dst = instruction_i[DST_HI:DST_LO];
    assign src = instruction_i[SRC_HI:SRC_LO];
    assign kk = instruction_i[KK_HI:KK_LO];
    assign aaa = instruction_i[DST_HI:0];
    assign can_push = (st.sp < SP_W'(STACK_DEPTH));
    assign can_pop = (st.sp != '0);
    assign ret_addr = st.stack[st.sp - SP_W'(1)] + 12'h001;
    assign ind_addr = {st.regs[dst][3:0], st.regs[src]};
    assign use_cy = (opc == OP_ADDCY_R) || (opc == OP_ADDCY_K);
    assign operand = opc[0] ? kk : st.regs[src];
    assign sum = {1'b0, st.regs[dst]} + {1'b0, operand}
        + {8'h00, use_cy & st.carry};

    // A held request stays in fetch, so sleeping costs no memory power.
    assign address_o = st.pc;
    assign bram_enable_o = (st.state == CORE_FETCH) && st.run
        && !sleep_i;
    assign port_bus_o = st.ports;
    assign wb_ack_o = st.wb_ack;
    assign wb_dat_o = st.wb_dat;

    assign scratch_code = 9'(SCRATCH_SIZE);
    assign status_word = {16'h0000, st.run,
        (st.state == CORE_FETCH) && sleep_i, st.carry, st.zero, st.pc};
    assign config_word = {3'h0, scratch_code, INTERRUPT_VECTOR,
        HWBUILD_VALUE};

    scbv_scratch #(
        .SIZE(SCRATCH_SIZE)
    ) u_scratch (
        .clk_i(clk_i),
        .we_i(scr_we),
        .addr_i(kk),
        .wdata_i(st.regs[dst]),
        .rdata_o(scr_rdata)
    );

    always_comb begin
        next_st = st;
        scr_we = 1'b0;
        next_st.ports.write_strobe = 1'b0;
        next_st.ports.const_write_strobe = 1'b0;
        next_st.ports.read_strobe = 1'b0;
        next_st.wb_ack = 1'b0;
        if (wb_cyc_i && wb_stb_i && !st.wb_ack) begin
            next_st.wb_ack = 1'b1;
            case (wb_adr_i)
                REG_CTRL: begin
                    next_st.wb_dat = {31'h00000000, st.run};
                    if (wb_we_i && wb_sel_i[0]) begin
                        next_st.run = wb_dat_i[CTRL_RUN_BIT];
                    end
                end
                REG_STATUS: next_st.wb_dat = status_word;
                REG_CONFIG: next_st.wb_dat = config_word;
                default: next_st.wb_dat = 32'h00000000;
            endcase
        end
        case (st.state)
            CORE_FETCH: begin
                if (st.ports.read_strobe) begin
                    next_st.regs[st.in_dst] = in_port_i;
                end
                if (st.run && !sleep_i) begin
                    next_st.state = CORE_EXEC;
                end
            end
            CORE_EXEC: begin
                next_st.state = CORE_FETCH;
                next_st.pc = st.pc + 12'h001;
                case (opc)
                    OP_LOAD_R, OP_LOAD_K: begin
                        next_st.regs[dst] = operand;
                    end
                    OP_ADD_R, OP_ADD_K, OP_ADDCY_R, OP_ADDCY_K: begin
                        next_st.regs[dst] = sum[DATA_W-1:0];
                        next_st.carry = sum[DATA_W];
                        // Chained adds keep zero meaning the whole result.
                        next_st.zero = (sum[DATA_W-1:0] == 8'h00)
                            && (!use_cy || st.zero);
                    end
                    OP_HWBUILD: begin
                        next_st.regs[dst] = HWBUILD_VALUE;
                        next_st.zero = (HWBUILD_VALUE == 8'h00);
                        next_st.carry = 1'b1;
                    end
                    OP_JUMP: next_st.pc = aaa;
                    OP_CALL, OP_CALL_IND: begin
                        if (can_push) begin
                            next_st.stack[st.sp] = st.pc;
                            next_st.sp = st.sp + SP_W'(1);
                        end
                        next_st.pc = (opc == OP_CALL) ? aaa
                            : ind_addr;
                    end
                    OP_RETURN, OP_LOAD_RET: begin
                        if (opc == OP_LOAD_RET) begin
                            next_st.regs[dst] = kk;
                        end
                        // An unbalanced return restarts at address zero.
                        if (can_pop) begin
                            next_st.pc = ret_addr;
                            next_st.sp = st.sp - SP_W'(1);
                        end else begin
                            next_st.pc = PC_RESET;
                        end
                    end
                    OP_OUTPUT: begin
                        next_st.ports.port_id = kk;
                        next_st.ports.data = st.regs[dst];
                        next_st.ports.write_strobe = 1'b1;
                    end
                    OP_CONSTANT_PORT_OUTPUT: begin
                        next_st.ports.port_id =
                            {4'h0, instruction_i[KPORT_HI:KPORT_LO]};
                        next_st.ports.data =
                            instruction_i[KVAL_HI:KVAL_LO];
                        next_st.ports.const_write_strobe = 1'b1;
                    end
                    OP_INPUT: begin
                        next_st.ports.port_id = kk;
                        next_st.ports.read_strobe = 1'b1;
                        next_st.in_dst = dst;
                    end
                    OP_STORE: scr_we = 1'b1;
                    OP_FETCH: next_st.regs[dst] = scr_rdata;
                    default: ;
                endcase
            end
            default: next_st.state = CORE_FETCH;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.pc <= PC_RESET;
            st.run <= CTRL_RUN_RESET;
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_build_reg_value: assert property (
        exec_now && opc == OP_HWBUILD
        |=> st.regs[$past(dst)] == HWBUILD_VALUE)
        else $error("build value not loaded");

    a_build_zero_flag: assert property (
        exec_now && opc == OP_HWBUILD
        |=> st.zero == (HWBUILD_VALUE == 8'h00))
        else $error("build load zero flag wrong");

    a_build_carry_set: assert property (
        exec_now && opc == OP_HWBUILD |=> st.carry ##1 st.carry)
        else $error("build load left carry clear");

    a_fetch_address_held: assert property (
        bram_enable_o |=> exec_now && address_o == $past(address_o))
        else $error("fetch address moved before execute");

    a_sleep_low_runs: assert property (
        st.state == CORE_FETCH && st.run && !sleep_i
        |=> exec_now ##1 st.state == CORE_FETCH)
        else $error("core stalled with sleep low");

    a_kstrobe_source: assert property (
        st.ports.const_write_strobe
        |-> $past(exec_now) && $past(opc) == OP_CONSTANT_PORT_OUTPUT
            && !st.ports.write_strobe)
        else $error("constant strobe without its instruction");

    a_config_readback: assert property (
        wb_cyc_i && wb_stb_i && !st.wb_ack && !wb_we_i
            && wb_adr_i == REG_CONFIG
        |=> wb_ack_o && wb_dat_o[19:8] == INTERRUPT_VECTOR
            && wb_dat_o[28:20] == scratch_code ##1 !wb_ack_o)
        else $error("config word wrong");

    a_call_ind_target: assert property (
        exec_now && opc == OP_CALL_IND && can_push
        |=> address_o == $past(ind_addr)
            && st.sp == $past(st.sp) + 5'h01
            && st.stack[$past(st.sp)] == $past(st.pc))
        else $error("indirect call target or push wrong");

    a_load_ret_two: assert property (
        exec_now && opc == OP_LOAD_RET && can_pop
        |=> st.state == CORE_FETCH && address_o == $past(ret_addr)
            && st.regs[$past(dst)] == $past(kk)
            && st.sp == $past(st.sp) - 5'h01)
        else $error("load and return wrong");

    a_kstrobe_pulse: assert property (
        st.ports.const_write_strobe |=> !st.ports.const_write_strobe)
        else $error("constant strobe longer than one cycle");

    a_config_build: assert property (
        wb_cyc_i && wb_stb_i && !st.wb_ack && wb_adr_i == REG_CONFIG
        |=> wb_dat_o[CFG_VEC_LO-1:CFG_BUILD_LO] == HWBUILD_VALUE)
        else $error("config build value wrong");

    a_sleep_holds: assert property (
        st.state == CORE_FETCH && sleep_i
        |=> st.state == CORE_FETCH && address_o == $past(address_o))
        else $error("core advanced while asleep");

    a_pc_step: assert property (
        exec_now && opc == OP_CONSTANT_PORT_OUTPUT
        |=> address_o == $past(address_o) + 12'h001)
        else $error("address did not step after output");

endmodule // scbv_core

// File: bench/scbv_prog_mem.sv
`timescale 1ns/1ps
module scbv_prog_mem
    import scbv_pkg::*;
(
    // Clock.
    input wire logic clk_i,
    // Fetch side.
    input wire logic en_i,
    input wire logic [ADDR_W-1:0] addr_i,
    output logic [INSTR_W-1:0] data_o
);
    // Filled by the bench before reset; a full 4K array decodes all twelve
    // address lines, where a 1K program could leave the top two open.
    logic [INSTR_W-1:0] rom [0:(1<<ADDR_W)-1];

    // Output holds while disabled, as a block memory does.
    always_ff @(posedge clk_i) begin
        if (en_i) begin
            data_o <= rom[addr_i];
        end
    end
endmodule // scbv_prog_mem

// File: bench/soft_cpu_build_value_and_ports_tb_top.sv
`timescale 1ns/1ps
module soft_cpu_build_value_and_ports_tb_top;
    import scbv_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sleep = 1'b0;
    logic tgt = 1'b0;
    logic cyc = 1'b0;
    logic wwe = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'hf;
    logic [7:0] inp = 8'h5a;
    logic [31:0] q;
    logic [1:0] ack;
    logic [1:0] en;
    logic [31:0] rd [2];
    logic [ADDR_W-1:0] pa [2];
    logic [INSTR_W-1:0] ins [2];
    scbv_port_bus_t pb [2];
    logic [18:0] ev_q [$];
    int t_q [$];
    int cycles = 0;
    int n_errors = 0;
    int checks = 0;

    initial forever #20 clk_i = ~clk_i;

    scbv_core #(.HWBUILD_VALUE(8'ha5), .INTERRUPT_VECTOR(12'h5c0),
        .SCRATCH_SIZE(128)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .address_o(pa[0]),
        .bram_enable_o(en[0]), .instruction_i(ins[0]), .sleep_i(sleep),
        .port_bus_o(pb[0]), .in_port_i(inp), .wb_cyc_i(cyc && !tgt),
        .wb_stb_i(cyc && !tgt), .wb_we_i(wwe), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd[0]),
        .wb_ack_o(ack[0]));
    // Default parameters, sleep tied low for the whole run.
    scbv_core dut_def (
        .clk_i(clk_i), .rst_i(rst_i), .address_o(pa[1]),
        .bram_enable_o(en[1]), .instruction_i(ins[1]), .sleep_i(1'b0),
        .port_bus_o(pb[1]), .in_port_i(inp), .wb_cyc_i(cyc && tgt),
        .wb_stb_i(cyc && tgt), .wb_we_i(wwe), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd[1]),
        .wb_ack_o(ack[1]));
    scbv_prog_mem pm0 (.clk_i(clk_i), .en_i(en[0]), .addr_i(pa[0]),
        .data_o(ins[0]));
    scbv_prog_mem pm1 (.clk_i(clk_i), .en_i(en[1]), .addr_i(pa[1]),
        .data_o(ins[1]));

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (pb[0].write_strobe || pb[0].const_write_strobe) begin
            ev_q.push_back(pb[0]);
            t_q.push_back(cycles);
        end
        if (cycles == 3000) begin
            n_errors++;
            $display("ERROR %0t timeout", $time);
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic cycle; waits for ack, takes data at that same edge.
    task automatic wb(input logic t, input logic we, input logic [3:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        tgt <= t;
        cyc <= 1'b1;
        wwe <= we;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack[t] !== 1'b1);
        q = rd[t];
        cyc <= 1'b0;
    endtask

    task automatic ld(input int a, input logic [5:0] op,
                      input logic [11:0] f);
        pm0.rom[a] = {op, f};
        pm1.rom[a] = {op, f};
    endtask

    initial begin
        for (int i = 0; i < 4096; i++) ld(i, OP_JUMP, 12'h00b);
        ld(0, OP_HWBUILD, 12'h100);
        ld(1, OP_OUTPUT, 12'h110);
        ld(2, OP_CONSTANT_PORT_OUTPUT, 12'h3c5);
        ld(3, OP_LOAD_K, 12'h20f);
        ld(4, OP_LOAD_K, 12'h302);
        ld(5, OP_CALL_IND, 12'h230);
        ld(6, OP_OUTPUT, 12'h420);
        // Scratch address 81 folds onto 01 in both scratch sizes used here.
        ld(7, OP_INPUT, 12'h533);
        ld(8, OP_STORE, 12'h581);
        ld(9, OP_FETCH, 12'h601);
        ld(10, OP_OUTPUT, 12'h644);
        ld(12'hf02, OP_LOAD_RET, 12'h477);
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (60) @(posedge clk_i);
        chk(ev_q.size(), 4);
        chk(ev_q[0], {8'h10, 8'ha5, 3'b100});
        chk(ev_q[1], {8'h05, 8'h3c, 3'b010});
        chk(ev_q[2], {8'h20, 8'h77, 3'b100});
        chk(t_q[1] - t_q[0], 2);
        chk(t_q[2] - t_q[1], 10);
        chk(ev_q[3], {8'h44, 8'h5a, 3'b100});
        chk(t_q[3] - t_q[2], 8);
        chk(pb[1], {8'h44, 8'h5a, 3'b000});
        chk(pa[0], 12'h00b);
        $display("test program done");
        wb(1'b0, 1'b0, 4'h4, 32'h0);
        chk(q, 32'h0000a00b);
        wb(1'b1, 1'b0, 4'h4, 32'h0);
        chk(q, 32'h0000b00b);
        wb(1'b0, 1'b0, 4'h8, 32'h0);
        chk(q, 32'h0805c0a5);
        wb(1'b1, 1'b0, 4'h8, 32'h0);
        chk(q, 32'h0403ff00);
        $display("test flags and config done");
        wb(1'b0, 1'b0, 4'h0, 32'h0);
        chk(q, 32'h1);
        wb(1'b0, 1'b1, 4'hc, 32'hffffffff);
        wb(1'b0, 1'b0, 4'hc, 32'h0);
        chk(q, 32'h0);
        // A control write without its low byte lane must be ignored.
        sel <= 4'he;
        wb(1'b0, 1'b1, 4'h0, 32'h0);
        sel <= 4'hf;
        wb(1'b0, 1'b0, 4'h0, 32'h0);
        chk(q, 32'h1);
        wb(1'b0, 1'b1, 4'h0, 32'h0);
        repeat (3) @(posedge clk_i);
        chk(en[0], 1'b0);
        wb(1'b0, 1'b1, 4'h0, 32'h1);
        sleep <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk(en[0], 1'b0);
        wb(1'b0, 1'b0, 4'h4, 32'h0);
        chk(q, 32'h0000e00b);
        sleep <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(en[0], 1'b1);
        @(posedge clk_i);
        chk(en[0], 1'b0);
        $display("test control and sleep done");
        stop_test();
    end
endmodule // soft_cpu_build_value_and_ports_tb_top
